// ### uems_params.svh
// constants of the uncorrectable error mask and severity register bank
// assumes a 12-bit byte address into extended configuration space
// Operation
// - severity bit one marks that error fatal, zero marks it nonfatal
// - severity register decoded as a 32-bit word at offset 10Ch
// - severity register reads 0006_2011h after any reset
// - severity bit 20, unsupported request, read/write, default nonfatal
// - severity bit 19, end-to-end crc, read/write, default nonfatal
// - severity bit 13, flow-control protocol error, read/write, default fatal
// - severity bit 4, link layer protocol error, read/write, default fatal
// - severity bit 0 is read-only and always reads one
// - severity bits 3:1 read-only, read zero, ignore writes
// - severity bits 31:21 read-only, always read zero
// - bits 11:5 read zero in both mask and severity registers
// - fundamental reset, global reset pin or power-on reset restore defaults
// - mask bits 20:12 and 4 read/write; zero unmasked and default, one masked
// - writable masks for completion, abort, timeout, flow-control, poisoned errors
// - writable link layer protocol mask bit, default unmasked
// - lowest mask nibble read-only, reads zero
// - masked error sets no status, no message, no log, no pointer update
// - mask register decoded at offset 108h, resets to all zeros
// - unsupported, crc, malformed and overflow mask bits read/write, default zero
`ifndef UEMS_PARAMS_SVH
`define UEMS_PARAMS_SVH

// register offsets, byte addresses
`define UEMS_MASK_OFS 12'h108
`define UEMS_SEV_OFS 12'h10C

// reset values
`define UEMS_MASK_RST 32'h0000_0000
`define UEMS_SEV_RST 32'h0006_2011

// bits that software may change, the same in both registers
`define UEMS_WR_BITS 32'h001F_F010

// field positions
`define UEMS_BIT_UR 20
`define UEMS_BIT_ECRC 19
`define UEMS_BIT_MAL 18
`define UEMS_BIT_OVF 17
`define UEMS_BIT_UNXP 16
`define UEMS_BIT_CA 15
`define UEMS_BIT_CTO 14
`define UEMS_BIT_FC 13
`define UEMS_BIT_PSN 12
`define UEMS_BIT_DLL 4

`endif

// ### uems_pkg.sv
// types shared by the register bank and its reporting stage
// assumes uems_params.svh supplies all numeric constants
package uems_pkg;

    // one configuration access from the configuration space decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } uems_cfg_req_t;

    // whole state of the register bank
    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] sev;
        logic [31:0] rdata;
        logic rd_valid;
        logic [1:0] perst_sq;
        logic [1:0] global_reset_pin_sq;
    } uems_bank_state_t;

    // whole state of the reporting stage
    typedef struct packed {
        logic [31:0] status_set;
        logic fatal_msg;
        logic nonfatal_msg;
        logic log_load;
    } uems_rep_state_t;

endpackage : uems_pkg

// ### uems_regs.sv
// uncorrectable error mask and severity registers with reporting gate
// assumes configuration accesses arrive decoded, on the core clock;
// fundamental reset and global reset pins arrive asynchronously
`timescale 1ns/1ps
`include "uems_params.svh"

module uems_regs
    import uems_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic perst_n_i,
    input wire logic global_reset_pin_n_i,
    input wire uems_cfg_req_t cfg_req_i,
    input wire logic [31:0] err_detect_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rd_valid_o,
    output logic [31:0] mask_o,
    output logic [31:0] sev_o,
    output logic [31:0] status_set_o,
    output logic fatal_msg_o,
    output logic nonfatal_msg_o,
    output logic log_load_o
);

    localparam logic [31:0] WR_BITS = `UEMS_WR_BITS;
    localparam logic [31:0] MASK_RST = `UEMS_MASK_RST;
    localparam logic [31:0] SEV_RST = `UEMS_SEV_RST;
    localparam logic [9:0] MASK_WORD = 10'(`UEMS_MASK_OFS >> 2);
    localparam logic [9:0] SEV_WORD = 10'(`UEMS_SEV_OFS >> 2);

    uems_bank_state_t st_ff;
    uems_bank_state_t nxt_st;

    logic [31:0] be_bits;
    logic hit_mask;
    logic hit_sev;
    logic pin_rst;

    // byte enables spread to one enable per data bit
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_be
            assign be_bits[gi] = cfg_req_i.be[gi / 8];
        end
    endgenerate

    // word decode; the two low address bits never select a register
    assign hit_mask = cfg_req_i.addr[11:2] == MASK_WORD;
    assign hit_sev = cfg_req_i.addr[11:2] == SEV_WORD;

    // either synchronised pin reset restores defaults
    assign pin_rst = st_ff.perst_sq[1] | st_ff.global_reset_pin_sq[1];

    // next state of the whole bank
    always_comb
    begin
        nxt_st = st_ff;
        // pins are async: two flops before anything looks at them
        nxt_st.perst_sq = {st_ff.perst_sq[0], ~perst_n_i};
        nxt_st.global_reset_pin_sq = {st_ff.global_reset_pin_sq[0], ~global_reset_pin_n_i};
        nxt_st.rd_valid = 1'b0;
        if (pin_rst)
        begin
            nxt_st.mask = MASK_RST;
            nxt_st.sev = SEV_RST;
            nxt_st.rdata = 32'h0000_0000;
        end
        else
        begin
            // only writable bits change; reserved bits keep their constants
            if (cfg_req_i.wr && hit_mask)
            begin
                nxt_st.mask = (st_ff.mask & ~(WR_BITS & be_bits))
                    | (cfg_req_i.wdata & WR_BITS & be_bits);
            end
            if (cfg_req_i.wr && hit_sev)
            begin
                nxt_st.sev = (st_ff.sev & ~(WR_BITS & be_bits))
                    | (cfg_req_i.wdata & WR_BITS & be_bits);
            end
            // reads answer one cycle later; unmapped words read zero
            if (cfg_req_i.rd)
            begin
                nxt_st.rd_valid = 1'b1;
                if (hit_mask)
                begin
                    nxt_st.rdata = st_ff.mask;
                end
                else if (hit_sev)
                begin
                    nxt_st.rdata = st_ff.sev;
                end
                else
                begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            end
        end
    end

    // power-on reset acts at once; pin resets take effect through the sync
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_ff <= '{mask: `UEMS_MASK_RST, sev: `UEMS_SEV_RST,
                       rdata: 32'h0000_0000, rd_valid: 1'b0,
                       perst_sq: 2'b11, global_reset_pin_sq: 2'b11};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_rdata_o = st_ff.rdata;
    assign cfg_rd_valid_o = st_ff.rd_valid;
    assign mask_o = st_ff.mask;
    assign sev_o = st_ff.sev;

    // reporting stage; flushed while a pin reset is held so nothing stale escapes
    uems_report u_report (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clr_i(pin_rst),
        .err_detect_i(err_detect_i),
        .mask_i(st_ff.mask),
        .sev_i(st_ff.sev),
        .status_set_o(status_set_o),
        .fatal_msg_o(fatal_msg_o),
        .nonfatal_msg_o(nonfatal_msg_o),
        .log_load_o(log_load_o)
    );

    // reset behaviour

    chk_sev_default: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        pin_rst |=> sev_o == 32'h0006_2011)
        else $error("severity not at default after reset");

    chk_mask_default: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        pin_rst |=> mask_o == 32'h0000_0000)
        else $error("mask not cleared after reset");

    chk_pin_reset: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!perst_n_i ##1 !perst_n_i) |=> ##1 (mask_o == 32'h0000_0000)
            && (sev_o == 32'h0006_2011))
        else $error("fundamental reset did not restore defaults");

    chk_global_reset_pin_reset: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!global_reset_pin_n_i ##1 !global_reset_pin_n_i) |=> ##1
            (mask_o == 32'h0000_0000) && (sev_o == 32'h0006_2011))
        else $error("global reset did not restore defaults");

    chk_ur_default: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        pin_rst |=> !sev_o[20] && !sev_o[19] && sev_o[13] && sev_o[4])
        else $error("per-error severity default wrong");

    // reserved fields

    chk_sev_bit0: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        sev_o[0] == 1'b1)
        else $error("severity bit 0 not one");

    chk_sev_reserved_field_low: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        sev_o[3:1] == 3'b000)
        else $error("severity bits 3:1 not zero");

    chk_sev_reserved_field_high: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        sev_o[31:21] == 11'h000)
        else $error("severity bits 31:21 not zero");

    chk_reserved_field_mid: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (sev_o[11:5] == 7'h00) && (mask_o[11:5] == 7'h00))
        else $error("bits 11:5 not zero");

    chk_mask_nibble: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        mask_o[3:0] == 4'h0)
        else $error("mask low nibble not zero");

    chk_mask_high: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        mask_o[31:21] == 11'h000)
        else $error("mask bits 31:21 not zero");

    // software writes

    chk_sev_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && cfg_req_i.be == 4'hF && !pin_rst)
            |=> sev_o == (($past(cfg_req_i.wdata) & 32'h001F_F010) | 32'h0000_0001))
        else $error("severity write not taken");

    chk_sev_fc_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && cfg_req_i.be[1] && !pin_rst)
            |=> sev_o[13] == $past(cfg_req_i.wdata[13]))
        else $error("flow-control severity not writable");

    chk_sev_dll_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && cfg_req_i.be[0] && !pin_rst)
            |=> sev_o[4] == $past(cfg_req_i.wdata[4]))
        else $error("link layer severity not writable");

    chk_mask_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_mask && cfg_req_i.be == 4'hF && !pin_rst)
            |=> mask_o == ($past(cfg_req_i.wdata) & 32'h001F_F010))
        else $error("mask write not taken");

    chk_mask_dll_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_mask && cfg_req_i.be[0] && !pin_rst)
            |=> mask_o[4] == $past(cfg_req_i.wdata[4]))
        else $error("link layer mask not writable");

    chk_mask_hold: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!(cfg_req_i.wr && hit_mask) && !pin_rst) |=> $stable(mask_o))
        else $error("mask changed without a write");

    // reads

    chk_read_sev: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.rd && hit_sev && !pin_rst)
            |=> cfg_rd_valid_o && (cfg_rdata_o == $past(sev_o)))
        else $error("severity read returned wrong data");

    chk_read_mask: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.rd && hit_mask && !pin_rst)
            |=> cfg_rd_valid_o && (cfg_rdata_o == $past(mask_o)))
        else $error("mask read returned wrong data");

    chk_read_pulse: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        cfg_rd_valid_o |-> $past(cfg_req_i.rd))
        else $error("read valid without a read");

    chk_valid_single: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !cfg_req_i.rd |=> !cfg_rd_valid_o)
        else $error("read valid stood longer than one cycle");

    chk_read_unmapped: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.rd && !hit_mask && !hit_sev && !pin_rst)
            |=> cfg_rd_valid_o && (cfg_rdata_o == 32'h0000_0000))
        else $error("unmapped read did not answer zero");

    chk_rdata_hold: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!cfg_req_i.rd && !pin_rst) |=> $stable(cfg_rdata_o))
        else $error("read data changed without a read");

    // byte lanes and per-field writes

    chk_sev_byte_keep: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && !pin_rst)
            |=> ((sev_o ^ $past(sev_o)) & ~$past(be_bits)) == 32'h0000_0000)
        else $error("severity byte changed without its enable");

    chk_mask_byte_keep: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_mask && !pin_rst)
            |=> ((mask_o ^ $past(mask_o)) & ~$past(be_bits)) == 32'h0000_0000)
        else $error("mask byte changed without its enable");

    chk_sev_hold: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!(cfg_req_i.wr && hit_sev) && !pin_rst) |=> $stable(sev_o))
        else $error("severity changed without a write");

    chk_sev_upper_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && cfg_req_i.be[2] && !pin_rst)
            |=> sev_o[20:16] == $past(cfg_req_i.wdata[20:16]))
        else $error("upper severity field not writable");

    chk_sev_mid_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_sev && cfg_req_i.be[1] && !pin_rst)
            |=> sev_o[15:12] == $past(cfg_req_i.wdata[15:12]))
        else $error("middle severity field not writable");

    chk_mask_upper_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_mask && cfg_req_i.be[2] && !pin_rst)
            |=> mask_o[20:16] == $past(cfg_req_i.wdata[20:16]))
        else $error("upper mask field not writable");

    chk_mask_mid_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (cfg_req_i.wr && hit_mask && cfg_req_i.be[1] && !pin_rst)
            |=> mask_o[15:12] == $past(cfg_req_i.wdata[15:12]))
        else $error("middle mask field not writable");

    // reporting against the live registers

    chk_report_flush: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        pin_rst |=> (status_set_o == 32'h0000_0000) && !fatal_msg_o
            && !nonfatal_msg_o && !log_load_o)
        else $error("report pulse escaped a pin reset");

    chk_report_idle: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (err_detect_i == 32'h0000_0000)
            |=> !fatal_msg_o && !nonfatal_msg_o && !log_load_o)
        else $error("report pulse without a detection");

    chk_log_load: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (|(err_detect_i & WR_BITS & ~mask_o) && !pin_rst) |=> log_load_o)
        else $error("unmasked error did not load the log");

    chk_unsup_fatal: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (err_detect_i[20] && !mask_o[20] && sev_o[20] && !pin_rst) |=> fatal_msg_o)
        else $error("fatal unsupported request not reported as fatal");

    chk_crc_nonfatal: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (err_detect_i[19] && !mask_o[19] && !sev_o[19] && !pin_rst) |=> nonfatal_msg_o)
        else $error("nonfatal crc error not reported as nonfatal");

    chk_flow_fatal: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (err_detect_i[13] && !mask_o[13] && sev_o[13] && !pin_rst) |=> fatal_msg_o)
        else $error("fatal flow-control error not reported as fatal");

endmodule : uems_regs

// ### uems_regs_test.sv
// self-checking testbench for the uncorrectable error mask and severity bank
// assumes uems_regs is the top, on one 100 MHz clock, with inputs driven 1 ns after the edge
`timescale 1ns/1ps

`define CHK(got, exp) check_val(32'(got), 32'(exp))

module uems_regs_test
    import uems_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic perst_n = 1'b1;
    logic global_reset_pin_n = 1'b1;
    uems_cfg_req_t cfg_req = '0;
    logic [31:0] err_detect = 32'h0000_0000;
    logic [31:0] cfg_rdata;
    logic cfg_rd_valid;
    logic [31:0] mask;
    logic [31:0] sev;
    logic [31:0] status_set;
    logic fatal_msg;
    logic nonfatal_msg;
    logic log_load;
    int err_count = 0;
    int n_compared = 0;

    uems_regs dut_u (
        .core_clk_i(core_clk),
        .rst_i(rst),
        .perst_n_i(perst_n),
        .global_reset_pin_n_i(global_reset_pin_n),
        .cfg_req_i(cfg_req),
        .err_detect_i(err_detect),
        .cfg_rdata_o(cfg_rdata),
        .cfg_rd_valid_o(cfg_rd_valid),
        .mask_o(mask),
        .sev_o(sev),
        .status_set_o(status_set),
        .fatal_msg_o(fatal_msg),
        .nonfatal_msg_o(nonfatal_msg),
        .log_load_o(log_load)
    );

    // free running core clock, 10 ns period
    always #5 core_clk = ~core_clk;

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : check_val

    // every input change lands the same small delay after a rising edge
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step

    task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be,
                             input logic [31:0] data);
        step();
        cfg_req.wr = 1'b1;
        cfg_req.addr = addr;
        cfg_req.be = be;
        cfg_req.wdata = data;
        step();
        cfg_req.wr = 1'b0;
    endtask : cfg_write

    // read answers exactly one cycle after the strobe, so look in that cycle
    task automatic cfg_read(input logic [11:0] addr, input logic [31:0] exp);
        step();
        cfg_req.rd = 1'b1;
        cfg_req.addr = addr;
        step();
        cfg_req.rd = 1'b0;
        `CHK(cfg_rd_valid, 1'b1);
        `CHK(cfg_rdata, exp);
    endtask : cfg_read

    // one detection pulse; flags are {fatal, nonfatal, log load}
    task automatic fire(input logic [31:0] err, input logic [31:0] exp_status,
                        input logic [2:0] exp_flags);
        step();
        err_detect = err;
        step();
        err_detect = 32'h0000_0000;
        `CHK(status_set, exp_status);
        `CHK({fatal_msg, nonfatal_msg, log_load}, exp_flags);
    endtask : fire

    task automatic test_defaults();
        cfg_read(12'h108, 32'h0000_0000);
        cfg_read(12'h10C, 32'h0006_2011);
        cfg_read(12'h110, 32'h0000_0000);
        `CHK(mask, 32'h0000_0000);
        `CHK(sev, 32'h0006_2011);
        $display("test defaults done");
    endtask : test_defaults

    // all ones then all zeros shows which bits are writable and which are fixed
    task automatic test_access();
        cfg_write(12'h108, 4'hF, 32'hFFFF_FFFF);
        cfg_write(12'h10C, 4'hF, 32'hFFFF_FFFF);
        cfg_read(12'h108, 32'h001F_F010);
        cfg_read(12'h10C, 32'h001F_F011);
        `CHK(mask & 32'h0000_0FEF, 32'h0000_0000);
        `CHK(sev & 32'h0000_0FEE, 32'h0000_0000);
        `CHK(mask[3:0], 4'h0);
        cfg_write(12'h108, 4'hF, 32'h0000_0000);
        cfg_write(12'h10C, 4'hF, 32'h0000_0000);
        cfg_read(12'h10C, 32'h0000_0001);
        cfg_read(12'h108, 32'h0000_0000);
        cfg_write(12'h108, 4'h2, 32'hFFFF_3000);
        `CHK(mask, 32'h0000_3000);
        cfg_write(12'h10C, 4'hF, 32'h0006_2011);
        cfg_write(12'h10C, 4'h1, 32'h0000_0000);
        cfg_read(12'h10C, 32'h0006_2001);
        cfg_write(12'h10C, 4'h4, 32'h0018_0000);
        `CHK(sev, 32'h0018_2001);
        $display("test access done");
    endtask : test_access

    task automatic test_report();
        cfg_write(12'h108, 4'hF, 32'h0004_1010);
        cfg_write(12'h10C, 4'hF, 32'h0010_2011);
        `CHK(mask, 32'h0004_1010);
        fire(32'h0010_0000, 32'h0010_0000, 3'b101);
        fire(32'h0008_0000, 32'h0008_0000, 3'b011);
        fire(32'h0000_1000, 32'h0000_0000, 3'b000);
        fire(32'h0000_0010, 32'h0000_0000, 3'b000);
        fire(32'h0004_0000, 32'h0000_0000, 3'b000);
        fire(32'h0000_0020, 32'h0000_0000, 3'b000);
        fire(32'h0000_6000, 32'h0000_6000, 3'b111);
        $display("test report done");
    endtask : test_report

    // each of the three resets must bring back both defaults
    task automatic test_resets();
        for (int i = 0; i < 3; i++)
        begin
            cfg_write(12'h108, 4'hF, 32'hFFFF_FFFF);
            cfg_write(12'h10C, 4'hF, 32'h0000_0000);
            step();
            if (i == 0)
                perst_n = 1'b0;
            else if (i == 1)
                global_reset_pin_n = 1'b0;
            else
                rst = 1'b1;
            if (i == 2)
            begin
                #1;
                `CHK(sev, 32'h0006_2011);
            end
            step();
            step();
            cfg_write(12'h108, 4'hF, 32'h0000_1000);
            perst_n = 1'b1;
            global_reset_pin_n = 1'b1;
            rst = 1'b0;
            repeat (4) step();
            `CHK(mask, 32'h0000_0000);
            `CHK(sev, 32'h0006_2011);
            cfg_read(12'h10C, 32'h0006_2011);
        end
        $display("test resets done");
    endtask : test_resets

    task automatic report_and_stop();
        $display("compared %0d values, %0d mismatches", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // main sequence: reset for ten cycles, then the tests in turn
    initial
    begin
        repeat (10) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (3) step();
        test_defaults();
        test_access();
        test_report();
        test_resets();
        report_and_stop();
    end

    // the tests need about 110 cycles; two thousand means a hang
    initial
    begin
        #20000;
        err_count++;
        report_and_stop();
    end

endmodule : uems_regs_test

// ### uems_report.sv
// reporting stage: gates detected errors by mask and classifies them
// assumes detection pulses come from logic on the same clock
`timescale 1ns/1ps
`include "uems_params.svh"

module uems_report
    import uems_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic [31:0] err_detect_i,
    input wire logic [31:0] mask_i,
    input wire logic [31:0] sev_i,
    output logic [31:0] status_set_o,
    output logic fatal_msg_o,
    output logic nonfatal_msg_o,
    output logic log_load_o
);

    localparam logic [31:0] WR_BITS = `UEMS_WR_BITS;

    uems_rep_state_t st_ff;
    uems_rep_state_t nxt_st;
    logic [31:0] live;

    // only implemented error positions may report; masked ones vanish here
    assign live = err_detect_i & WR_BITS & ~mask_i;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.status_set = live;
        nxt_st.fatal_msg = |(live & sev_i);
        nxt_st.nonfatal_msg = |(live & ~sev_i);
        nxt_st.log_load = |live;
        if (clr_i)
        begin
            nxt_st = '0;
        end
    end

    // registered so every output leaves a flip-flop
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign status_set_o = st_ff.status_set;
    assign fatal_msg_o = st_ff.fatal_msg;
    assign nonfatal_msg_o = st_ff.nonfatal_msg;
    assign log_load_o = st_ff.log_load;

    chk_masked_quiet: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!clr_i && (err_detect_i & ~mask_i & WR_BITS) == 32'h0000_0000)
            |=> (status_set_o == 32'h0000_0000) && !fatal_msg_o && !nonfatal_msg_o && !log_load_o)
        else $error("masked error leaked into reporting");

    chk_fatal_class: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!clr_i && |(err_detect_i & WR_BITS & ~mask_i & sev_i)) |=> fatal_msg_o)
        else $error("fatal error not reported as fatal");

    chk_nonfatal_class: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!clr_i && |(err_detect_i & WR_BITS & ~mask_i & ~sev_i)) |=> nonfatal_msg_o)
        else $error("nonfatal error not reported as nonfatal");

    chk_status_pos: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !clr_i |=> status_set_o == $past(err_detect_i & WR_BITS & ~mask_i))
        else $error("status set at wrong bit position");

endmodule : uems_report
